// ---- logic/uart_core_pkg.sv ----
// Constants, register map and types of the asynchronous serial core
`default_nettype none
package uart_core_pkg;
	localparam int ADDR_W = 18;
	// Register indices; byte address is four times the index
	localparam logic [15:0] IDX_MODE = 16'hff50;
	localparam logic [15:0] IDX_RXBUF = 16'hff51;
	localparam logic [15:0] IDX_STATUS = 16'hff53;
	localparam logic [15:0] IDX_TXBUF = 16'hff54;
	localparam logic [15:0] IDX_PROGRESS = 16'hff55;
	localparam logic [15:0] IDX_PERIOD = 16'hff57;
	localparam logic [ADDR_W-1:0] ADDR_MODE = {IDX_MODE, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_RXBUF = {IDX_RXBUF, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_TXBUF = {IDX_TXBUF, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_PROGRESS = {IDX_PROGRESS, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_PERIOD = {IDX_PERIOD, 2'b00};
	// Reset values
	localparam logic [7:0] MODE_RST = 8'h01;
	localparam logic [2:0] STATUS_RST = 3'h0;
	localparam logic [7:0] TXBUF_RST = 8'hff;
	localparam logic [7:0] RXBUF_RST = 8'hff;
	localparam logic [7:0] PERIOD_RST = 8'hff;
	// Field positions in the error and progress registers
	localparam int PE_BIT = 2;
	localparam int FE_BIT = 1;
	localparam int OV_BIT = 0;
	localparam int TXBF_BIT = 1;
	localparam int TXSF_BIT = 0;
	// Parity selections
	localparam logic [1:0] PAR_NONE = 2'b00;
	localparam logic [1:0] PAR_ZERO = 2'b01;
	localparam logic [1:0] PAR_ODD = 2'b10;
	localparam logic [1:0] PAR_EVEN = 2'b11;
	// Base-clock cycles after power-on before the bit counter runs
	localparam logic [1:0] POWER_UP_CYCLES = 2'd2;
	// Last data-bit index for 7 and 8 bit characters
	localparam logic [2:0] LAST_BIT_7 = 3'd6;
	localparam logic [2:0] LAST_BIT_8 = 3'd7;

	typedef struct packed {
		logic unit_power_on;
		logic transmit_enable;
		logic receive_enable;
		logic parity_select_hi;
		logic parity_select_lo;
		logic char_length_sel;
		logic stop_count_sel;
		logic error_irq_routing;
	} mode_t;

	typedef enum logic [2:0] {
		TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP
	} tx_state_t;

	typedef enum logic [2:0] {
		RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP
	} rx_state_t;
endpackage
`default_nettype wire

// ---- logic/async_serial_tx_rx_core.sv ----
// Asynchronous serial transmitter and receiver with an APB register slave
//
// Function
// - Writing the transmit holding buffer starts a transmission; resets to 0xff.
// - First byte moves to shifter at once; next byte as the last stop bit ends, with completion.
// - Shifter loads with the start bit; data, parity and stop bits follow on the base clock bit tick.
// - Mode register resets to 0x01: power, tx, rx, parity, length, stop, routing.
// - Power zero stops the unit and asynchronously resets its state.
// - Power zero holds the output pin high and input treated high.
// - Bit counter output runs only from the second cycle after power-on.
// - Clearing an enable synchronously resets that direction's circuit.
// - Parity field: none, zero, odd, even for send and check.
// - Zero parity reception never checks parity nor raises a parity error.
// - Length bit selects seven or eight data bits both ways.
// - Stop setting gives one or two stop bits; receiver checks one.
// - Errors raise the error interrupt, or with routing set the normal one.
// - Enabling reception on a low line starts a reception at once.
// - Error status holds parity, framing, overrun; cleared on read or disable.
// - Parity error set when received parity disagrees with computed parity.
// - Framing error set when the stop bit samples low.
// - Overrun set when a character completes before the buffer was read.
// - Seven-bit data lands in low bits with the top bit zero.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module async_serial_tx_rx_core (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [uart_core_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic serial_in_pin,
	output logic serial_out_pin,
	output logic tx_complete_irq,
	output logic rx_complete_irq,
	output logic rx_error_irq
);
	uart_core_pkg::mode_t mode;
	logic [7:0] transmit_holding_buffer;
	logic [7:0] receive_holding_buffer;
	logic [7:0] bit_period;
	logic [2:0] receive_error_status;
	logic rx_full;
	logic tx_buffer_full_flag;
	logic tx_busy;
	logic [1:0] power_cnt;
	logic baud_ok;
	logic core_rst_n;
	logic access;
	logic wr_en;
	logic rd_en;
	logic mapped;
	logic [7:0] period_last;
	logic [7:0] period_half;
	logic [2:0] last_bit;
	logic [1:0] par_mode;
	logic rx_line;

	uart_core_pkg::tx_state_t tx_state;
	logic [7:0] transmit_shifter;
	logic [7:0] tx_cnt;
	logic [2:0] tx_bitn;
	logic tx_par;
	logic tx_stopn;
	logic tx_tick;
	logic tx_load;
	logic next_tx_par;

	uart_core_pkg::rx_state_t rx_state;
	logic [7:0] receive_shifter;
	logic [7:0] rx_cnt;
	logic [2:0] rx_bitn;
	logic rx_acc;
	logic rx_par;
	logic rx_tick;
	logic [7:0] rx_data;
	logic rx_pe;
	logic rx_fe;
	logic rx_ov;

	assign access = psel & penable & pready;
	assign wr_en = access & pwrite;
	assign rd_en = access & ~pwrite;
	assign core_rst_n = nrst & mode.unit_power_on;
	assign rx_line = mode.unit_power_on ? serial_in_pin : 1'b1;
	assign period_last = (bit_period == 8'h00) ? 8'h00 : bit_period - 8'h01;
	assign period_half = {1'b0, bit_period[7:1]};
	assign last_bit = mode.char_length_sel ? uart_core_pkg::LAST_BIT_8
		: uart_core_pkg::LAST_BIT_7;
	assign par_mode = {mode.parity_select_hi, mode.parity_select_lo};
	assign baud_ok = (power_cnt == uart_core_pkg::POWER_UP_CYCLES);
	assign mapped = (paddr == uart_core_pkg::ADDR_MODE)
		| (paddr == uart_core_pkg::ADDR_RXBUF)
		| (paddr == uart_core_pkg::ADDR_STATUS)
		| (paddr == uart_core_pkg::ADDR_TXBUF)
		| (paddr == uart_core_pkg::ADDR_PROGRESS)
		| (paddr == uart_core_pkg::ADDR_PERIOD);

	// APB answer one cycle into the access phase
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~mapped;
			prdata <= 32'h0000_0000;
			if (psel & penable & ~pready & ~pwrite) begin
				case (paddr)
				uart_core_pkg::ADDR_MODE: prdata <= {24'h000000, mode};
				uart_core_pkg::ADDR_RXBUF: prdata <= {24'h000000,
					receive_holding_buffer};
				uart_core_pkg::ADDR_STATUS: prdata <= {29'h00000000,
					receive_error_status};
				uart_core_pkg::ADDR_TXBUF: prdata <= {24'h000000,
					transmit_holding_buffer};
				uart_core_pkg::ADDR_PROGRESS: prdata <= {30'h00000000,
					tx_buffer_full_flag, tx_busy};
				uart_core_pkg::ADDR_PERIOD: prdata <= {24'h000000, bit_period};
				default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Software-written registers
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			mode <= uart_core_pkg::MODE_RST;
			transmit_holding_buffer <= uart_core_pkg::TXBUF_RST;
			bit_period <= uart_core_pkg::PERIOD_RST;
		end else if (wr_en) begin
			case (paddr)
			uart_core_pkg::ADDR_MODE: mode <= pwdata[7:0];
			uart_core_pkg::ADDR_TXBUF:
				transmit_holding_buffer <= pwdata[7:0];
			uart_core_pkg::ADDR_PERIOD: bit_period <= pwdata[7:0];
			default: mode <= mode;
			endcase
		end
	end

	// Power-up delay before the bit counters may run
	always_ff @(posedge mclk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			power_cnt <= 2'd0;
		end else if (!baud_ok) begin
			power_cnt <= power_cnt + 2'd1;
		end
	end

	// Transmitter
	assign tx_tick = (tx_state != uart_core_pkg::TX_IDLE)
		& (tx_cnt == period_last);
	assign tx_load = tx_buffer_full_flag & baud_ok
		& ((tx_state == uart_core_pkg::TX_IDLE)
		| ((tx_state == uart_core_pkg::TX_STOP) & tx_tick
		& ~(mode.stop_count_sel & ~tx_stopn)));

	always_comb begin
		case (par_mode)
		uart_core_pkg::PAR_ODD: next_tx_par = ~^{transmit_holding_buffer[7]
			& mode.char_length_sel, transmit_holding_buffer[6:0]};
		uart_core_pkg::PAR_EVEN: next_tx_par = ^{transmit_holding_buffer[7]
			& mode.char_length_sel, transmit_holding_buffer[6:0]};
		default: next_tx_par = 1'b0;
		endcase
	end

	always_ff @(posedge mclk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			tx_state <= uart_core_pkg::TX_IDLE;
			transmit_shifter <= 8'hff;
			tx_cnt <= 8'h00;
			tx_bitn <= 3'd0;
			tx_par <= 1'b0;
			tx_stopn <= 1'b0;
			tx_buffer_full_flag <= 1'b0;
			tx_busy <= 1'b0;
			serial_out_pin <= 1'b1;
			tx_complete_irq <= 1'b0;
		end else if (!mode.transmit_enable) begin
			tx_state <= uart_core_pkg::TX_IDLE;
			tx_cnt <= 8'h00;
			tx_buffer_full_flag <= 1'b0;
			tx_busy <= 1'b0;
			serial_out_pin <= 1'b1;
			tx_complete_irq <= 1'b0;
		end else begin
			tx_complete_irq <= 1'b0;
			tx_cnt <= (tx_tick | (tx_state == uart_core_pkg::TX_IDLE))
				? 8'h00 : tx_cnt + 8'h01;
			if (tx_load) begin
				// Shifter loads and start bit goes out together
				transmit_shifter <= transmit_holding_buffer;
				tx_par <= next_tx_par;
				tx_buffer_full_flag <= 1'b0;
				tx_busy <= 1'b1;
				tx_state <= uart_core_pkg::TX_START;
				tx_cnt <= 8'h00;
				serial_out_pin <= 1'b0;
				if (tx_state == uart_core_pkg::TX_STOP) begin
					tx_complete_irq <= 1'b1;
				end
			end else if (tx_tick) begin
				case (tx_state)
				uart_core_pkg::TX_START: begin
					serial_out_pin <= transmit_shifter[0];
					transmit_shifter <= {1'b1, transmit_shifter[7:1]};
					tx_bitn <= 3'd0;
					tx_state <= uart_core_pkg::TX_DATA;
				end
				uart_core_pkg::TX_DATA: begin
					if (tx_bitn == last_bit) begin
						if (par_mode != uart_core_pkg::PAR_NONE) begin
							serial_out_pin <= tx_par;
							tx_state <= uart_core_pkg::TX_PARITY;
						end else begin
							serial_out_pin <= 1'b1;
							tx_stopn <= 1'b0;
							tx_state <= uart_core_pkg::TX_STOP;
						end
					end else begin
						serial_out_pin <= transmit_shifter[0];
						transmit_shifter <= {1'b1, transmit_shifter[7:1]};
						tx_bitn <= tx_bitn + 3'd1;
					end
				end
				uart_core_pkg::TX_PARITY: begin
					serial_out_pin <= 1'b1;
					tx_stopn <= 1'b0;
					tx_state <= uart_core_pkg::TX_STOP;
				end
				uart_core_pkg::TX_STOP: begin
					if (mode.stop_count_sel & ~tx_stopn) begin
						tx_stopn <= 1'b1;
					end else begin
						tx_complete_irq <= 1'b1;
						tx_busy <= 1'b0;
						tx_state <= uart_core_pkg::TX_IDLE;
					end
				end
				default: tx_state <= uart_core_pkg::TX_IDLE;
				endcase
			end
			// Buffer write marks data pending; set wins over transfer
			if (wr_en & (paddr == uart_core_pkg::ADDR_TXBUF)) begin
				tx_buffer_full_flag <= 1'b1;
			end
		end
	end

	// Receiver
	assign rx_tick = (rx_state == uart_core_pkg::RX_START)
		? (rx_cnt == period_half) : (rx_cnt == period_last);
	assign rx_data = mode.char_length_sel ? receive_shifter
		: {1'b0, receive_shifter[7:1]};
	assign rx_pe = ((par_mode == uart_core_pkg::PAR_ODD)
		| (par_mode == uart_core_pkg::PAR_EVEN))
		& ((rx_acc ^ rx_par) != (par_mode == uart_core_pkg::PAR_ODD));
	assign rx_fe = ~rx_line;
	assign rx_ov = rx_full;

	always_ff @(posedge mclk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			rx_state <= uart_core_pkg::RX_IDLE;
			receive_shifter <= 8'hff;
			rx_cnt <= 8'h00;
			rx_bitn <= 3'd0;
			rx_acc <= 1'b0;
			rx_par <= 1'b0;
			rx_complete_irq <= 1'b0;
			rx_error_irq <= 1'b0;
		end else if (!mode.receive_enable) begin
			rx_state <= uart_core_pkg::RX_IDLE;
			rx_cnt <= 8'h00;
			rx_complete_irq <= 1'b0;
			rx_error_irq <= 1'b0;
		end else begin
			rx_complete_irq <= 1'b0;
			rx_error_irq <= 1'b0;
			rx_cnt <= (rx_tick | (rx_state == uart_core_pkg::RX_IDLE))
				? 8'h00 : rx_cnt + 8'h01;
			case (rx_state)
			uart_core_pkg::RX_IDLE: begin
				if (~rx_line & baud_ok) begin
					rx_state <= uart_core_pkg::RX_START;
				end
			end
			uart_core_pkg::RX_START: begin
				if (rx_tick) begin
					rx_bitn <= 3'd0;
					rx_acc <= 1'b0;
					rx_state <= rx_line ? uart_core_pkg::RX_IDLE
						: uart_core_pkg::RX_DATA;
				end
			end
			uart_core_pkg::RX_DATA: begin
				if (rx_tick) begin
					receive_shifter <= {rx_line, receive_shifter[7:1]};
					rx_acc <= rx_acc ^ rx_line;
					rx_bitn <= rx_bitn + 3'd1;
					if (rx_bitn == last_bit) begin
						rx_state <= (par_mode != uart_core_pkg::PAR_NONE)
							? uart_core_pkg::RX_PARITY
							: uart_core_pkg::RX_STOP;
					end
				end
			end
			uart_core_pkg::RX_PARITY: begin
				if (rx_tick) begin
					rx_par <= rx_line;
					rx_state <= uart_core_pkg::RX_STOP;
				end
			end
			uart_core_pkg::RX_STOP: begin
				// Only one stop bit is ever checked
				if (rx_tick) begin
					if (rx_pe | rx_fe | rx_ov) begin
						rx_error_irq <= ~mode.error_irq_routing;
						rx_complete_irq <= mode.error_irq_routing;
					end else begin
						rx_complete_irq <= 1'b1;
					end
					rx_state <= uart_core_pkg::RX_IDLE;
				end
			end
			default: rx_state <= uart_core_pkg::RX_IDLE;
			endcase
		end
	end

	// Receive buffer and error flags; a new event wins over a read
	always_ff @(posedge mclk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			receive_holding_buffer <= uart_core_pkg::RXBUF_RST;
			rx_full <= 1'b0;
			receive_error_status <= uart_core_pkg::STATUS_RST;
		end else if (!mode.receive_enable) begin
			rx_full <= 1'b0;
			receive_error_status <= uart_core_pkg::STATUS_RST;
		end else begin
			if (rd_en & (paddr == uart_core_pkg::ADDR_RXBUF)) begin
				rx_full <= 1'b0;
			end
			if (rd_en & (paddr == uart_core_pkg::ADDR_STATUS)) begin
				receive_error_status <= 3'h0;
			end
			if ((rx_state == uart_core_pkg::RX_STOP) & rx_tick) begin
				receive_error_status <= ((rd_en
					& (paddr == uart_core_pkg::ADDR_STATUS))
					? 3'h0 : receive_error_status)
					| {rx_pe, rx_fe, rx_ov};
				if (!rx_ov) begin
					receive_holding_buffer <= rx_data;
					rx_full <= 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ---- dv/async_serial_tx_rx_core_props.sv ----
// Port-level assertions for the asynchronous serial core
`timescale 1ns/1ps
`default_nettype none
module async_serial_tx_rx_core_props (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [uart_core_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic serial_in_pin,
	input wire logic serial_out_pin,
	input wire logic tx_complete_irq,
	input wire logic rx_complete_irq,
	input wire logic rx_error_irq
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);
	logic mapped;
	assign mapped = paddr inside {uart_core_pkg::ADDR_MODE,
		uart_core_pkg::ADDR_RXBUF, uart_core_pkg::ADDR_STATUS,
		uart_core_pkg::ADDR_TXBUF, uart_core_pkg::ADDR_PROGRESS,
		uart_core_pkg::ADDR_PERIOD};
	a_ready_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
		else $error("pready not in second access cycle");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_ready_in_access: assert property (pready |-> psel && penable)
		else $error("pready outside access phase");
	a_unmapped_err: assert property (pready && !mapped |-> pslverr && !prdata)
		else $error("unmapped access not refused");
	a_status_upper_zero: assert property (
		pready && !pwrite && paddr == uart_core_pkg::ADDR_STATUS |->
		prdata[31:3] == 29'h0) else $error("status upper bits set");
	a_irq_exclusive: assert property (rx_error_irq |-> !rx_complete_irq)
		else $error("both reception interrupts raised");
	a_stop_before_done: assert property (
		tx_complete_irq |-> $past(serial_out_pin) && !$past(tx_complete_irq))
		else $error("frame done without high stop bit");
	a_rx_irq_pulse: assert property (
		rx_complete_irq || rx_error_irq |=> !rx_complete_irq && !rx_error_irq)
		else $error("reception interrupt not a pulse");
endmodule
bind async_serial_tx_rx_core async_serial_tx_rx_core_props props_u (
	.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .serial_in_pin(serial_in_pin),
	.serial_out_pin(serial_out_pin), .tx_complete_irq(tx_complete_irq),
	.rx_complete_irq(rx_complete_irq), .rx_error_irq(rx_error_irq));
`default_nettype wire

// ---- dv/serial_node_model.sv ----
// Remote serial node: sends frames and samples frames at mid bit
`timescale 1ns/1ps
`default_nettype none
module serial_node_model #(
	parameter int BIT_CYC = 8
) (
	input wire logic mclk,
	input wire logic line_in,
	output logic line_out
);
	initial line_out = 1'b1;
	task automatic send(input logic [11:0] fr, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge mclk);
			line_out <= fr[i];
			repeat (BIT_CYC - 1) @(posedge mclk);
		end
		@(posedge mclk);
		line_out <= 1'b1;
	endtask
	task automatic take(input int n, output logic [11:0] fr);
		int k;
		fr = 12'hfff;
		k = 0;
		while (line_in !== 1'b0 && k < 1000) begin
			@(posedge mclk);
			k++;
		end
		for (int i = 0; i < n; i++) begin
			repeat (i == 0 ? BIT_CYC / 2 : BIT_CYC) @(posedge mclk);
			fr[i] = line_in;
		end
	endtask
endmodule
`default_nettype wire

// ---- dv/async_serial_tx_rx_core_tb_top.sv ----
// Self-checking bench for the asynchronous serial core
`timescale 1ns/1ps
`default_nettype none
module async_serial_tx_rx_core_tb_top;
	localparam int BIT_CYC = 8;
	localparam logic [17:0] M = uart_core_pkg::ADDR_MODE;
	localparam logic [17:0] ST = uart_core_pkg::ADDR_STATUS;
	localparam logic [17:0] TB = uart_core_pkg::ADDR_TXBUF;
	localparam logic [17:0] RB = uart_core_pkg::ADDR_RXBUF;
	localparam logic [17:0] PG = uart_core_pkg::ADDR_PROGRESS;
	logic mclk, nrst, psel, penable, pwrite, pready, pslverr, rerr;
	logic serial_in_pin, serial_out_pin, tx_complete_irq;
	logic rx_complete_irq, rx_error_irq;
	logic [17:0] paddr;
	logic [31:0] pwdata, prdata, rdata;
	logic [7:0] m;
	logic [11:0] f, g, f2, g2;
	logic [1:0] q;
	int n, miscompares, checks_done, cyc;
	// Mode format, data sent, byte expected back
	logic [23:0] rows [6] = '{24'h04a5a5, 24'h0ac343, 24'h163c3c,
		24'h18ff7f, 24'h110000, 24'h1c8181};
	// Address, error expected, value expected
	logic [26:0] regs [6] = '{{M, 9'h001}, {ST, 9'h000}, {TB, 9'h0ff},
		{RB, 9'h0ff}, {PG, 9'h000}, {18'h3fd58, 9'h100}};
	async_serial_tx_rx_core dut_u (.mclk(mclk), .nrst(nrst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
		.tx_complete_irq(tx_complete_irq), .rx_complete_irq(rx_complete_irq),
		.rx_error_irq(rx_error_irq));
	serial_node_model #(.BIT_CYC(BIT_CYC)) node_u (.mclk(mclk),
		.line_in(serial_out_pin), .line_out(serial_in_pin));
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			miscompares = miscompares + 1;
			end_sim();
		end
	end
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [17:0] a, input logic [7:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge mclk);
		penable <= 1'b1;
		// Wait for the answer; only the bench timeout ends a hang
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function automatic int mk(input logic [7:0] mm, input logic [7:0] d,
		output logic [11:0] fr);
		int k;
		logic p;
		k = mm[2] ? 8 : 7;
		p = ^(d & (mm[2] ? 8'hff : 8'h7f));
		fr = 12'hfff;
		fr[0] = 1'b0;
		for (int i = 0; i < k; i++) fr[i + 1] = d[i];
		if (mm[4:3] != 2'b00) begin
			fr[k + 1] = mm[4] & (p ^ ~mm[3]);
			k++;
		end
		return k + 2 + int'(mm[1]);
	endfunction
	task automatic cfg(input logic [7:0] mm);
		apb(1'b1, M, 8'h80 | m);
		m = mm;
		apb(1'b1, M, 8'h80 | m);
		apb(1'b1, M, 8'he0 | m);
	endtask
	task automatic rxf(input logic [1:0] e);
		int k;
		k = 0;
		fork
			node_u.send(f, n);
			begin
				do begin
					@(posedge mclk);
					k++;
				end while (!(rx_complete_irq | rx_error_irq) && k < 200);
				q = {rx_error_irq, rx_complete_irq};
			end
		join
		chk("rx_irq", 32'(q), 32'(e));
	endtask
	task automatic rd(input logic [17:0] a, input string nm, input logic [7:0] e);
		apb(1'b0, a, 8'h0);
		chk(nm, rdata, {24'h0, e});
	endtask
	// Frame-done pulse comes at the end of the last stop bit
	task automatic txd;
		int k;
		k = 0;
		do begin
			@(posedge mclk);
			k++;
		end while (tx_complete_irq !== 1'b1 && k < 2 * BIT_CYC);
		chk("tx_done", 32'(tx_complete_irq), 32'h1);
		chk("tx_done_at", 32'(k), 32'(BIT_CYC / 2));
	endtask
	initial begin
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 18'h0;
		pwdata = 32'h0;
		m = 8'h01;
		repeat (6) @(posedge mclk);
		nrst <= 1'b1;
		apb(1'b1, uart_core_pkg::ADDR_PERIOD, 8'(BIT_CYC));
		foreach (rows[i]) begin
			cfg(rows[i][23:16]);
			rd(M, "mode", 8'he0 | m);
			n = mk(m, rows[i][15:8], f);
			fork
				node_u.take(n, g);
				apb(1'b1, TB, rows[i][15:8]);
			join
			chk("tx_frame", 32'(g), 32'(f));
			txd();
			rxf(2'b01);
			rd(RB, "rx_data", rows[i][7:0]);
			rd(ST, "status", 8'h00);
		end
		cfg(8'h10);
		n = mk(m, 8'h55, f);
		f[8] = ~f[8];
		rxf(2'b10);
		rd(ST, "pe_flag", 8'h04);
		rd(ST, "rd_clear", 8'h00);
		cfg(8'h08);
		n = mk(m, 8'h55, f);
		f[8] = 1'b1;
		rxf(2'b01);
		rd(ST, "zero_par", 8'h00);
		cfg(8'h07);
		n = mk(m, 8'h12, f);
		f[9] = 1'b0;
		rxf(2'b01);
		rd(ST, "fe_flag", 8'h02);
		cfg(8'h04);
		n = mk(m, 8'h3a, f);
		rxf(2'b01);
		n = mk(m, 8'hc5, f);
		rxf(2'b10);
		rd(ST, "ov_flag", 8'h01);
		rd(RB, "ov_keep", 8'h3a);
		n = mk(m, 8'h11, f);
		void'(mk(m, 8'h22, f2));
		fork
			node_u.take(n, g);
			begin
				apb(1'b1, TB, 8'h11);
				rd(PG, "moved", 8'h01);
				apb(1'b1, TB, 8'h22);
				rd(PG, "queued", 8'h03);
			end
		join
		node_u.take(n, g2);
		chk("frame_1", 32'(g), 32'(f));
		chk("frame_2", 32'(g2), 32'(f2));
		apb(1'b1, TB, 8'h00);
		repeat (20) @(posedge mclk);
		apb(1'b1, M, 8'ha0 | m);
		repeat (2) @(posedge mclk);
		chk("tx_off_pin", 32'(serial_out_pin), 32'h1);
		rd(PG, "tx_off", 8'h00);
		apb(1'b1, M, 8'h80 | m);
		apb(1'b1, M, 8'h00);
		apb(1'b1, TB, 8'h5a);
		repeat (2 * BIT_CYC) @(posedge mclk);
		chk("off_pin", 32'(serial_out_pin), 32'h1);
		rd(RB, "off_rxbuf", 8'hff);
		nrst <= 1'b0;
		repeat (6) @(posedge mclk);
		nrst <= 1'b1;
		apb(1'b1, ST, 8'h07);
		foreach (regs[i]) begin
			rd(regs[i][26:9], "reg_val", regs[i][7:0]);
			chk("reg_err", 32'(rerr), 32'(regs[i][8]));
		end
		end_sim();
	end
endmodule
`default_nettype wire
